// file: hdl/perf_monitor_map.svh
// Purpose: Register offsets, field positions, widths and timing for the counter bank.
// Assumes: An 8-bit register port with a 5-bit address.
// Notes:   Definitions only; included by the package and the design.
`ifndef PERF_MONITOR_MAP_SVH
`define PERF_MONITOR_MAP_SVH

// ==========================================================================
// Port widths, counter storage and timebase width
`define PM_ADDR_W          5
`define PM_DATA_W          8
`define PM_CNT_W           16
`define PM_NUM_COUNTERS    9
`define PM_TICK_W          28

// ==========================================================================
// Indirect mapping addresses
`define PM_ADDR_CRC4_LO    5'h00
`define PM_ADDR_CRC4_HI    5'h01
`define PM_ADDR_FRAME_LO   5'h02
`define PM_ADDR_FRAME_HI   5'h03
`define PM_ADDR_ALIGN      5'h04
`define PM_ADDR_SYNC       5'h05
`define PM_ADDR_PATTERN_LO 5'h06
`define PM_ADDR_PATTERN_HI 5'h07
`define PM_ADDR_LINE_LO    5'h08
`define PM_ADDR_LINE_HI    5'h09
`define PM_ADDR_NCRC_LO    5'h0A
`define PM_ADDR_NCRC_HI    5'h0B
`define PM_ADDR_FBLK_LO    5'h0C
`define PM_ADDR_FBLK_HI    5'h0D
`define PM_ADDR_NFBLK_LO   5'h0E
`define PM_ADDR_NFBLK_HI   5'h0F
`define PM_ADDR_CTRL       5'h10
`define PM_ADDR_STATUS     5'h11

// ==========================================================================
// Control bits and reset values
`define PM_CTRL_AUTO_BIT   0
`define PM_CTRL_MANUAL_BIT 1
`define PM_CTRL_HDB3_BIT   2
`define PM_CTRL_RESET      3'h0
`define PM_READ_ZERO       8'h00
`define PM_TICK_RESET      28'h0000000
`define PM_SNAPCNT_RESET   8'h00

// ==========================================================================
// Counter widths
`define PM_W_CRC4          10
`define PM_W_FRAME         12
`define PM_W_ALIGN         3
`define PM_W_SYNC          5
`define PM_W_PATTERN       16
`define PM_W_LINE          16
`define PM_W_NCRC          10
`define PM_W_FBLK          10
`define PM_W_NFBLK         10

// ==========================================================================
// Timing
`define PM_SECOND_NS       1000000000
`define PM_CLK_PERIOD_NS   5

`endif

// file: hdl/perf_monitor_pkg.sv
// Purpose: Types shared by the counter bank.
// Assumes: perf_monitor_map.svh gives the counter, timebase and data widths; ctrl, snap_count and the index enum are sized here.
// Notes:   Counter indices follow the order of the mapping addresses.
`default_nettype none
`include "perf_monitor_map.svh"

package perf_monitor_pkg;

  // ========================================================================
  // Counter storage
  typedef logic [`PM_CNT_W-1:0]                           count_t;
  typedef logic [`PM_NUM_COUNTERS-1:0][`PM_CNT_W-1:0]     count_arr_t;

  typedef enum logic [3:0] {
    IDX_CRC4, IDX_FRAME, IDX_ALIGN, IDX_SYNC, IDX_PATTERN,
    IDX_LINE, IDX_NCRC, IDX_FBLK, IDX_NFBLK
  } counter_idx_e;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [2:0]              ctrl;
    logic [`PM_TICK_W-1:0]   tick;
    logic [7:0]              snap_count;
    count_arr_t              run;
    count_arr_t              snap;
    logic [`PM_DATA_W-1:0]   rdata;
  } perf_state_s;

endpackage : perf_monitor_pkg
`default_nettype wire

// file: hdl/perf_monitor.sv
// Purpose: Performance-monitoring counter bank of one E1 receive link.
// Assumes: Event inputs are one-cycle pulses from logic on sys_clk.
// Notes:   Snapshot registers are read-only; control sits at its own address.
//
// Contract
// - A zero-to-one write of manual_snapshot copies all counts to mapping registers.
// - With auto_snapshot set, mapping registers refresh once every second.
// - Mapping registers 00h to 0Fh load together as one coherent snapshot.
// - CRC-4 error count, 10 bits: low byte at 00h, bits 9:8 at 01h[5:4].
// - Framing error count, 12 bits: low byte at 02h, upper nibble 03h[3:0].
// - Alignment shift count, 3 bits at 04h, counts changed alignment positions.
// - Sync loss count, 5 bits at 05h[4:0].
// - Pattern detector bit error count, 16 bits at 06h (low) and 07h.
// - Line violation count, 16 bits at 08h/09h; AMI or HDB3 violations.
// - Near-end CRC error count, 10 bits: low byte 0Ah, bits 9:8 at 0Bh[5:4].
// - Far-end block error count, 10 bits: low byte 0Ch, bits 9:8 at 0Dh[5:4].
// - Near-end far-end-block-error count low byte at 0Eh, read only.
// - Near-end far-end-block-error count is 10 bits; bits 9:8 at 0Fh[1:0].
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "perf_monitor_map.svh"

module perf_monitor #(
  parameter int SECOND_CYCLES = `PM_SECOND_NS / `PM_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [`PM_ADDR_W-1:0] reg_addr,
  input  wire logic [`PM_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [`PM_DATA_W-1:0] reg_rdata,
  // Event pulses from the framer
  input  wire logic                  crc4_error_event,
  input  wire logic                  framing_error_event,
  input  wire logic                  align_shift_event,
  input  wire logic                  sync_loss_event,
  input  wire logic                  pattern_detector_error_event,
  input  wire logic                  bipolar_violation_event,
  input  wire logic                  hdb3_violation_event,
  input  wire logic                  near_crc_error_event,
  input  wire logic                  far_block_error_event,
  input  wire logic                  near_far_block_error_event,
  // Snapshot indication
  output logic                       snapshot_taken
);

  // ========================================================================
  // Counter limits
  localparam logic [`PM_TICK_W-1:0] TICK_LAST = `PM_TICK_W'(SECOND_CYCLES - 1);

  function automatic int width_of(int idx);
    case (idx)
      perf_monitor_pkg::IDX_CRC4:    width_of = `PM_W_CRC4;
      perf_monitor_pkg::IDX_FRAME:   width_of = `PM_W_FRAME;
      perf_monitor_pkg::IDX_ALIGN:   width_of = `PM_W_ALIGN;
      perf_monitor_pkg::IDX_SYNC:    width_of = `PM_W_SYNC;
      perf_monitor_pkg::IDX_PATTERN: width_of = `PM_W_PATTERN;
      perf_monitor_pkg::IDX_LINE:    width_of = `PM_W_LINE;
      perf_monitor_pkg::IDX_NCRC:    width_of = `PM_W_NCRC;
      perf_monitor_pkg::IDX_FBLK:    width_of = `PM_W_FBLK;
      default:                       width_of = `PM_W_NFBLK;
    endcase
  endfunction : width_of

  function automatic perf_monitor_pkg::count_t max_of(int idx);
    max_of = `PM_CNT_W'((33'h1 << width_of(idx)) - 33'h1);
  endfunction : max_of

  // ========================================================================
  // State
  perf_monitor_pkg::perf_state_s s_q;
  perf_monitor_pkg::perf_state_s s_d;

  logic [`PM_NUM_COUNTERS-1:0] events;
  logic                        line_event;
  logic                        manual_edge;
  logic                        auto_tick;
  logic                        snap_now;

  // The decoder mode picks which violation pulse feeds the line counter.
  assign line_event = s_q.ctrl[`PM_CTRL_HDB3_BIT] ? hdb3_violation_event
                                                  : bipolar_violation_event;

  always_comb begin
    events                                  = '0;
    events[perf_monitor_pkg::IDX_CRC4]      = crc4_error_event;
    events[perf_monitor_pkg::IDX_FRAME]     = framing_error_event;
    events[perf_monitor_pkg::IDX_ALIGN]     = align_shift_event;
    events[perf_monitor_pkg::IDX_SYNC]      = sync_loss_event;
    events[perf_monitor_pkg::IDX_PATTERN]   = pattern_detector_error_event;
    events[perf_monitor_pkg::IDX_LINE]      = line_event;
    events[perf_monitor_pkg::IDX_NCRC]      = near_crc_error_event;
    events[perf_monitor_pkg::IDX_FBLK]      = far_block_error_event;
    events[perf_monitor_pkg::IDX_NFBLK]     = near_far_block_error_event;
  end

  // ========================================================================
  // Snapshot triggers
  // Only the rising edge of the stored bit counts, so software must write a
  // zero before the next manual request.
  assign manual_edge = reg_wr && (reg_addr == `PM_ADDR_CTRL)
                       && reg_wdata[`PM_CTRL_MANUAL_BIT]
                       && !s_q.ctrl[`PM_CTRL_MANUAL_BIT];
  assign auto_tick   = s_q.ctrl[`PM_CTRL_AUTO_BIT] && (s_q.tick == TICK_LAST);
  assign snap_now    = manual_edge || auto_tick;

  // ========================================================================
  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.rdata = `PM_READ_ZERO;

    // Control register write.
    if (reg_wr && (reg_addr == `PM_ADDR_CTRL)) begin
      s_d.ctrl = reg_wdata[2:0];
    end

    // One-second timebase; held at zero while automatic refresh is off so the
    // first refresh comes a full second after it is enabled.
    if (!s_q.ctrl[`PM_CTRL_AUTO_BIT] || auto_tick) begin
      s_d.tick = `PM_TICK_RESET;
    end else begin
      s_d.tick = s_q.tick + `PM_TICK_W'(1);
    end

    // Counters; an event in the snapshot cycle starts the new interval at one.
    for (int i = 0; i < `PM_NUM_COUNTERS; i++) begin
      if (snap_now) begin
        s_d.snap[i] = s_q.run[i];
        s_d.run[i]  = events[i] ? `PM_CNT_W'(1) : `PM_CNT_W'(0);
      end else if (events[i] && (s_q.run[i] != max_of(i))) begin
        s_d.run[i]  = s_q.run[i] + `PM_CNT_W'(1);
      end
    end

    if (snap_now) begin
      s_d.snap_count = s_q.snap_count + 8'h01;
    end

    // Read data stands in the cycle after the strobe only.
    if (reg_rd) begin
      unique case (reg_addr)
        `PM_ADDR_CRC4_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_CRC4][7:0];
        `PM_ADDR_CRC4_HI:
          s_d.rdata = {2'h0, s_q.snap[perf_monitor_pkg::IDX_CRC4][9:8], 4'h0};
        `PM_ADDR_FRAME_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_FRAME][7:0];
        `PM_ADDR_FRAME_HI:
          s_d.rdata = {4'h0, s_q.snap[perf_monitor_pkg::IDX_FRAME][11:8]};
        `PM_ADDR_ALIGN:
          s_d.rdata = {5'h00, s_q.snap[perf_monitor_pkg::IDX_ALIGN][2:0]};
        `PM_ADDR_SYNC:
          s_d.rdata = {3'h0, s_q.snap[perf_monitor_pkg::IDX_SYNC][4:0]};
        `PM_ADDR_PATTERN_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_PATTERN][7:0];
        `PM_ADDR_PATTERN_HI:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_PATTERN][15:8];
        `PM_ADDR_LINE_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_LINE][7:0];
        `PM_ADDR_LINE_HI:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_LINE][15:8];
        `PM_ADDR_NCRC_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_NCRC][7:0];
        `PM_ADDR_NCRC_HI:
          s_d.rdata = {2'h0, s_q.snap[perf_monitor_pkg::IDX_NCRC][9:8], 4'h0};
        `PM_ADDR_FBLK_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_FBLK][7:0];
        `PM_ADDR_FBLK_HI:
          s_d.rdata = {2'h0, s_q.snap[perf_monitor_pkg::IDX_FBLK][9:8], 4'h0};
        `PM_ADDR_NFBLK_LO:
          s_d.rdata = s_q.snap[perf_monitor_pkg::IDX_NFBLK][7:0];
        `PM_ADDR_NFBLK_HI:
          s_d.rdata = {6'h00, s_q.snap[perf_monitor_pkg::IDX_NFBLK][9:8]};
        `PM_ADDR_CTRL:
          s_d.rdata = {5'h00, s_q.ctrl};
        `PM_ADDR_STATUS:
          s_d.rdata = s_q.snap_count;
        default:
          s_d.rdata = `PM_READ_ZERO;
      endcase
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q.ctrl       <= `PM_CTRL_RESET;
      s_q.tick       <= `PM_TICK_RESET;
      s_q.snap_count <= `PM_SNAPCNT_RESET;
      s_q.run        <= '0;
      s_q.snap       <= '0;
      s_q.rdata      <= `PM_READ_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata      = s_q.rdata;
  assign snapshot_taken = snap_now;

endmodule : perf_monitor
`default_nettype wire

// file: verification/perf_monitor_sva.sv
// Purpose: Port-level checks of the counter bank.
// Assumes: A shadow of the control register follows writes to 10h.
// Notes:   Mapping contents are compared by the bench.
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Checker
module perf_monitor_sva #(
  parameter int SECOND_CYCLES = 50
) (
  // Watched ports
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       snapshot_taken
);
  logic [2:0]  ctrl_q;
  logic [27:0] tick_q;
  logic [7:0]  cnt_q;
  logic        man_go;
  logic        tick_end;
  assign man_go = reg_wr && reg_addr == 5'h10 && reg_wdata[1] && !ctrl_q[1];
  assign tick_end = ctrl_q[0] && tick_q == 28'(SECOND_CYCLES - 1);
  function automatic logic [7:0] rsv(input logic [4:0] a);
    case (a)
      5'h01, 5'h0B, 5'h0D: rsv = 8'hCF;
      5'h03: rsv = 8'hF0;
      5'h04: rsv = 8'hF8;
      5'h05: rsv = 8'hE0;
      5'h0F: rsv = 8'hFC;
      default: rsv = 8'h00;
    endcase
  endfunction : rsv
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= 3'h0;
      tick_q <= 28'h0000000;
      cnt_q  <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 5'h10) ctrl_q <= reg_wdata[2:0];
      tick_q <= (!ctrl_q[0] || tick_end) ? 28'h0000000 : tick_q + 28'h0000001;
      if (snapshot_taken) cnt_q <= cnt_q + 8'h01;
    end
  end
  a_manual_snap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    man_go |-> snapshot_taken) else $error("manual trigger gave no snapshot");
  a_rearm_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == 5'h10 && ctrl_q == 3'h2 |-> !snapshot_taken)
    else $error("snapshot without a rising trigger");
  a_auto_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick_end |-> snapshot_taken) else $error("periodic snapshot missing");
  a_snap_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    snapshot_taken |-> man_go || tick_end) else $error("snapshot without cause");
  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(reg_rd) |-> (reg_rdata & rsv($past(reg_addr))) == 8'h00)
    else $error("reserved bits not zero");
  a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(reg_rd && reg_addr == 5'h10) |-> reg_rdata == {5'h00, $past(ctrl_q)})
    else $error("control readback wrong");
  a_status_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(reg_rd && reg_addr == 5'h11) |-> reg_rdata == $past(cnt_q))
    else $error("snapshot count wrong");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(reg_rd) || $past(reg_addr) > 5'h11 |-> reg_rdata == 8'h00)
    else $error("read data not zero");
endmodule : perf_monitor_sva
bind perf_monitor perf_monitor_sva #(.SECOND_CYCLES(SECOND_CYCLES)) perf_monitor_sva_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .snapshot_taken(snapshot_taken));
`default_nettype wire

// file: verification/e1_perf_monitor_counters_test.sv
// Purpose: Self-checking bench of the counter bank.
// Assumes: A 50-cycle second keeps the periodic snapshot short.
// Notes:   Counts are modelled per event and compared per mapping byte.
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Bench
module e1_perf_monitor_counters_test;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [9:0]  ev = 10'h000;
  logic [7:0]  reg_rdata, v;
  logic        snapshot_taken, man, hdb3;
  logic [15:0] cnt [9];
  logic [15:0] snp [9];
  int          err_count = 0, total_checks = 0, seed = 22916, cyc = 0, snaps = 0, k;
  always #2.5 sys_clk = ~sys_clk;
  perf_monitor #(.SECOND_CYCLES(50)) perf_monitor_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crc4_error_event(ev[0]), .framing_error_event(ev[1]), .align_shift_event(ev[2]),
    .sync_loss_event(ev[3]), .pattern_detector_error_event(ev[4]),
    .bipolar_violation_event(ev[5]), .hdb3_violation_event(ev[6]),
    .near_crc_error_event(ev[7]), .far_block_error_event(ev[8]),
    .near_far_block_error_event(ev[9]), .snapshot_taken(snapshot_taken));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test;
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Saturation ceiling of each running counter.
  function automatic logic [15:0] top(input int i);
    case (i)
      1: top = 16'h0FFF;
      2: top = 16'h0007;
      3: top = 16'h001F;
      4, 5: top = 16'hFFFF;
      default: top = 16'h03FF;
    endcase
  endfunction : top
  task automatic step(input logic [4:0] a, input logic [7:0] d, input logic w,
                      input logic r, input logic [9:0] m);
    int j, i;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= r;
    ev <= m;
    if (w && a == 5'h10 && d[1] && !man) begin
      snp = cnt;
      cnt = '{default: 16'h0000};
      snaps++;
    end
    for (j = 0; j < 10; j++) begin
      i = (j > 5) ? j - 1 : j;
      if (m[j] && (j != 5 || !hdb3) && (j != 6 || hdb3) && cnt[i] != top(i)) cnt[i]++;
    end
    if (w && a == 5'h10) {hdb3, man} = d[2:1];
  endtask : step
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    step(a, 8'h00, 1'b0, 1'b1, 10'h000);
    step(5'h00, 8'h00, 1'b0, 1'b0, 10'h000);
    #1 q = reg_rdata;
  endtask : rd
  function automatic logic [7:0] expv(input logic [4:0] a);
    logic [15:0] s;
    s = snp[(a < 5'h04) ? a[4:1] : (a < 5'h06) ? a - 5'h02 : a[4:1] + 5'h01];
    if (a == 5'h04 || a == 5'h05 || !a[0]) expv = s[7:0];
    else if (a == 5'h03 || a > 5'h05 && a < 5'h0A || a == 5'h0F) expv = s[15:8];
    else expv = {2'b00, s[9:8], 4'h0};
  endfunction : expv
  task automatic readall;
    for (int a = 0; a < 16; a++) begin
      rd(a[4:0], v);
      chk("mapping", v, expv(a[4:0]));
    end
  endtask : readall
  initial begin
    man = 1'b0;
    hdb3 = 1'b0;
    cnt = '{default: 16'h0000};
    snp = cnt;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 32; k = k + ((k == 19) ? 12 : 1)) begin
      rd(k[4:0], v);
      chk("reset value", v, 8'h00);
    end
    $display("reset values done");
    for (k = 0; k < 2; k++) begin
      step(5'h10, {5'h00, k[0], 2'b00}, 1'b1, 1'b0, 10'h000);
      repeat (200) step(5'h00, 8'h00, 1'b0, 1'b0, 10'($random(seed)));
      step(5'h10, {5'h00, k[0], 2'b10}, 1'b1, 1'b0, 10'($random(seed)));
      step(5'h10, {5'h00, k[0], 2'b00}, 1'b1, 1'b0, 10'h000);
      step(5'h00, 8'hFF, 1'b1, 1'b0, 10'h000);
      readall;
    end
    $display("random counting done");
    step(5'h10, 8'h02, 1'b1, 1'b0, 10'h000);
    step(5'h10, 8'h02, 1'b1, 1'b0, 10'h000);
    rd(5'h11, v);
    chk("snapshot count", v, snaps[7:0]);
    step(5'h10, 8'h00, 1'b1, 1'b0, 10'h000);
    $display("manual trigger done");
    repeat (3) step(5'h00, 8'h00, 1'b0, 1'b0, 10'h001);
    step(5'h10, 8'h01, 1'b1, 1'b0, 10'h000);
    k = 0;
    do begin
      step(5'h00, 8'h00, 1'b0, 1'b0, 10'h000);
      #1 k++;
    end while (snapshot_taken !== 1'b1 && k < 60);
    chk("auto period", k[7:0], 8'h32);
    snp = cnt;
    cnt = '{default: 16'h0000};
    snaps++;
    step(5'h10, 8'h00, 1'b1, 1'b0, 10'h000);
    readall;
    rd(5'h11, v);
    chk("snapshot count", v, snaps[7:0]);
    $display("periodic snapshot done");
    finish_test;
  end
endmodule : e1_perf_monitor_counters_test
`default_nettype wire
